// [hdl/serial_port_pkg.sv]
// constants, modes and carrier types for the four-mode serial port
package serial_port_pkg;
    typedef enum logic [1:0] {
        MODE_SYNC   = 2'b00,
        MODE_ASYNC8 = 2'b01,
        MODE_FIXED9 = 2'b10,
        MODE_VAR9   = 2'b11
    } mode_t;

    typedef enum logic [1:0] {
        TX_IDLE  = 2'b00,
        TX_ASYNC = 2'b01,
        TX_SYNC  = 2'b10
    } tx_state_t;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_BITS  = 2'b10,
        RX_SYNC  = 2'b11
    } rx_state_t;

    // sync shift clock: twelve system clocks per bit, low half then high half
    localparam logic [3:0] SYNC_DIV_LAST = 4'hb;
    localparam logic [3:0] SYNC_CLK_RISE = 4'h6;
    // sixteen-times oversampling of each asynchronous bit
    localparam logic [3:0] OVS_LAST      = 4'hf;
    localparam logic [3:0] OVS_MID       = 4'h7;
    // fixed 9-bit mode: 16x tick every 4 clocks (sysclk/64) or 2 (sysclk/32)
    localparam logic [1:0] FIX_SLOW_LAST = 2'h3;
    localparam logic [1:0] FIX_FAST_LAST = 2'h1;
    // bits per frame, start bit included in the async modes
    localparam logic [3:0] SYNC_BITS     = 4'h8;
    localparam logic [3:0] ASYNC8_BITS   = 4'ha;
    localparam logic [3:0] ASYNC9_BITS   = 4'hb;
    localparam logic [1:0] CLKSEL_TIMER8 = 2'h0;
    localparam logic [10:0] TX_SH_RST    = 11'h7ff;
    localparam logic [9:0]  RX_SH_RST    = 10'h000;

    typedef struct packed {
        mode_t      mode;
        logic       multiproc_check_bit;
        logic       receiver_enable_bit;
        logic       ninth_tx_bit;
        logic       baud_doubler_bit;
        logic [1:0] tx_clock_select;
        logic [1:0] rx_clock_select;
        logic [7:0] slave_address_value;
        logic [7:0] slave_address_mask;
        logic       irq_enable;
    } serial_cfg_t;

    typedef struct packed {
        logic       ninth_rx_bit;
        logic [7:0] data;
    } rx_word_t;

    typedef struct packed {
        logic frame_error_flag;
        logic receive_overrun_flag;
        logic transmit_collision_flag;
        logic tx_done_flag;
        logic rx_done_flag;
    } status_t;

    localparam status_t STATUS_RST = 5'h00;
    localparam rx_word_t WORD_RST  = 9'h000;
endpackage

// [hdl/serial_port.sv]
// four-mode serial port with ninth-bit multiprocessor address recognition
//
// Functional notes
// - sync mode: data both ways on input pin, shift clock driven on output pin
// - sync mode: buffer write sends eight bits lsb first, tx done after eighth
// - sync receive starts when enabled and rx done clear; done one cycle late
// - sync mode shift clock is system clock divided by twelve
// - 8-bit async frame: start, eight data lsb first, stop; ten bits
// - async modes: buffer write starts transmit; tx done at stop-bit start
// - 8-bit async: load data, stop into ninth bit, only if rx done clear
// - async receiver accepts frames any time once receive enable is set
// - variable baud takes one clock per timer overflow, per second 8-bit overflow without doubler
// - transmit and receive baud sources chosen by separate two-bit selects
// - 8-bit timer source: baud is overflow/32, or overflow/16 with doubler
// - 16-bit timer source: baud is overflow rate divided by sixteen
// - 9-bit modes send ninth tx bit; received ninth bit stored, stop not needed to load
// - 9-bit load needs rx done clear and, with check on, ninth set and match
// - fixed 9-bit mode runs at sysclk/64, or sysclk/32 with doubler
// - variable 9-bit mode: eleven-bit frame with timer-derived baud
// - address bytes carry ninth bit one, data bytes ninth bit zero
// - masked match compares only address bits whose mask bit is one
// - masked and broadcast addresses are both accepted at once
// - slave software clears check bit after address, sets it after message
// - interrupt, when enabled, while tx done or rx done is set
// - done flags are cleared only by software, never by hardware
// - broadcast address is address OR mask; its zero bits are don't care
// - async overrun when new byte lands before previous read; frame error on low stop
// - collision flag when buffer is written during a transmit, every mode
`timescale 1ns/1ps
module serial_port (
    input  wire logic                         mclk,
    input  wire logic                         sys_rst,
    input  wire serial_port_pkg::serial_cfg_t cfg,
    input  wire logic                         eight_bit_timer_ovf,
    input  wire logic [2:0]                   sixteen_bit_timer_ovf,
    input  wire logic                         tx_wr,
    input  wire logic [7:0]                   tx_wr_data,
    input  wire serial_port_pkg::status_t     flag_clr,
    input  wire logic                         rx_rd_ready,
    output logic                              rx_rd_valid,
    output serial_port_pkg::rx_word_t         serial_buffer,
    output serial_port_pkg::status_t          status,
    output logic                              serial_irq,
    output logic                              serial_out_pin,
    input  wire logic                         serial_in_pin_i,
    output logic                              serial_in_pin_o,
    output logic                              serial_in_pin_oe_n
);
    import serial_port_pkg::*;

    // either masked or broadcast match makes an address valid
    function automatic logic addr_match(input logic [7:0] rx, input logic [7:0] adr,
                                        input logic [7:0] msk);
        logic [7:0] bcast;
        bcast = adr | msk;
        addr_match = (((rx ^ adr) & msk) == 8'h00)
                   | ((~rx & bcast) == 8'h00);
    endfunction

    // overflow of the timer picked by a two-bit select
    function automatic logic ovf_pick(input logic [1:0] sel, input logic t8,
                                      input logic [2:0] t16);
        ovf_pick = (sel == CLKSEL_TIMER8) ? t8 : t16[sel - 2'h1];
    endfunction

    tx_state_t   tx_state_q;
    rx_state_t   rx_state_q;
    logic [10:0] tx_sh_q;
    logic [9:0]  rx_sh_q;
    logic [3:0]  tx_bits_q, rx_bits_q, tx_tcnt_q, rx_tcnt_q, sph_q;
    logic [1:0]  fix_q, half_q;
    rx_word_t    head_q, tail_q;
    logic        head_v_q, tail_v_q;
    status_t     status_q;
    logic        irq_q, out_pin_q, in_o_q, in_oe_n_q;

    logic        is_sync, is_a8, fix_tick, tx_tick, rx_tick;
    logic [1:0]  tick_w;
    logic [3:0]  frame_bits;
    logic [10:0] tx_load;
    logic        tx_start, tx_collide, tx_ti_evt, rx_sync_go;
    logic [9:0]  fr;
    logic [7:0]  rx_data;
    logic        rx_ninth, rx_stop, async_end, sync_end, rx_qual, rx_load, pop;
    rx_word_t    rx_word;
    status_t     set_w;

    // mode decode and frame length
    assign is_sync    = (cfg.mode == MODE_SYNC);
    assign is_a8      = (cfg.mode == MODE_ASYNC8);
    assign frame_bits = is_sync ? SYNC_BITS : (is_a8 ? ASYNC8_BITS : ASYNC9_BITS);

    // fixed-rate prescaler for the 9-bit fixed mode
    assign fix_tick = (fix_q == (cfg.baud_doubler_bit ? FIX_FAST_LAST : FIX_SLOW_LAST));
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            fix_q <= 2'h0;
        end else begin
            fix_q <= fix_tick ? 2'h0 : fix_q + 2'h1;
        end
    end

    // 16x ticks per direction; the 8-bit timer needs a halving stage without the doubler
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_baud
            logic [1:0] sel;
            logic       raw;
            assign sel = (gi == 0) ? cfg.tx_clock_select : cfg.rx_clock_select;
            assign raw = ovf_pick(sel, eight_bit_timer_ovf, sixteen_bit_timer_ovf);
            assign tick_w[gi] = (cfg.mode == MODE_FIXED9) ? fix_tick
                              : raw & ((sel != CLKSEL_TIMER8) | cfg.baud_doubler_bit
                                       | half_q[gi]);
            always_ff @(posedge mclk or posedge sys_rst) begin
                if (sys_rst) begin
                    half_q[gi] <= 1'b0;
                end else if (raw && sel == CLKSEL_TIMER8) begin
                    half_q[gi] <= ~half_q[gi];
                end
            end
        end
    endgenerate
    assign tx_tick = tick_w[0];
    assign rx_tick = tick_w[1];

    // shared sync phase counter, restarted on each sync transfer
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sph_q <= 4'h0;
        end else if ((tx_start && is_sync) || rx_sync_go || sph_q == SYNC_DIV_LAST) begin
            sph_q <= 4'h0;
        end else begin
            sph_q <= sph_q + 4'h1;
        end
    end

    // transmit start; half duplex in sync mode so a receive in flight also collides
    assign tx_start   = tx_wr && tx_state_q == TX_IDLE && rx_state_q != RX_SYNC;
    assign tx_collide = tx_wr && !tx_start;
    assign tx_load    = is_sync ? {3'b111, tx_wr_data}
                      : is_a8 ? {2'b11, tx_wr_data, 1'b0}
                      : {1'b1, cfg.ninth_tx_bit, tx_wr_data, 1'b0};
    assign tx_ti_evt  = (tx_state_q == TX_ASYNC && tx_tick && tx_tcnt_q == OVS_LAST
                         && tx_bits_q == 4'h2)
                      | (tx_state_q == TX_SYNC && sph_q == SYNC_DIV_LAST
                         && tx_bits_q == 4'h1);

    // transmit shifter; bit 0 is always the bit on the line
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_state_q <= TX_IDLE;
            tx_sh_q    <= TX_SH_RST;
            tx_bits_q  <= 4'h0;
            tx_tcnt_q  <= 4'h0;
        end else begin
            case (tx_state_q)
                TX_IDLE: begin
                    if (tx_start) begin
                        tx_sh_q    <= tx_load;
                        tx_bits_q  <= frame_bits;
                        tx_tcnt_q  <= 4'h0;
                        tx_state_q <= is_sync ? TX_SYNC : TX_ASYNC;
                    end
                end
                TX_ASYNC: begin
                    if (tx_tick) begin
                        tx_tcnt_q <= tx_tcnt_q + 4'h1;
                        if (tx_tcnt_q == OVS_LAST) begin
                            tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
                            tx_bits_q <= tx_bits_q - 4'h1;
                            if (tx_bits_q == 4'h1) begin
                                tx_state_q <= TX_IDLE;
                            end
                        end
                    end
                end
                TX_SYNC: begin
                    if (sph_q == SYNC_DIV_LAST) begin
                        tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
                        tx_bits_q <= tx_bits_q - 4'h1;
                        if (tx_bits_q == 4'h1) begin
                            tx_state_q <= TX_IDLE;
                        end
                    end
                end
                default: tx_state_q <= TX_IDLE;
            endcase
        end
    end

    // receive frame decode; the final sample joins the shifter from the top
    assign rx_sync_go = is_sync && cfg.receiver_enable_bit && !status_q.rx_done_flag
                     && rx_state_q == RX_IDLE && tx_state_q == TX_IDLE && !tx_wr;
    assign fr        = {serial_in_pin_i, rx_sh_q[9:1]};
    assign rx_data   = is_a8 ? fr[8:1] : fr[7:0];
    assign rx_stop   = fr[9];
    assign rx_ninth  = is_a8 ? rx_stop : fr[8];
    assign async_end = rx_state_q == RX_BITS && rx_tick && rx_tcnt_q == OVS_LAST
                    && rx_bits_q == 4'h1;
    assign sync_end  = rx_state_q == RX_SYNC && sph_q == SYNC_DIV_LAST
                    && rx_bits_q == 4'h0;
    assign rx_qual   = sync_end
                     | (async_end && (is_a8 ? (!cfg.multiproc_check_bit | rx_stop)
                        : (!cfg.multiproc_check_bit
                           | (rx_ninth && addr_match(rx_data, cfg.slave_address_value,
                                                     cfg.slave_address_mask)))));
    // a full holding buffer drops the byte; only async frames report it as overrun
    assign rx_load   = rx_qual && !status_q.rx_done_flag && !tail_v_q;
    assign rx_word   = sync_end ? {1'b0, rx_sh_q[9:2]} : {rx_ninth, rx_data};

    // receive engine: start edge, centre sampling and sync shifting
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_state_q <= RX_IDLE;
            rx_sh_q    <= RX_SH_RST;
            rx_bits_q  <= 4'h0;
            rx_tcnt_q  <= 4'h0;
        end else begin
            case (rx_state_q)
                RX_IDLE: begin
                    rx_tcnt_q <= 4'h0;
                    if (rx_sync_go) begin
                        rx_bits_q  <= SYNC_BITS;
                        rx_state_q <= RX_SYNC;
                    end else if (!is_sync && cfg.receiver_enable_bit && rx_tick
                                 && !serial_in_pin_i) begin
                        rx_state_q <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_tick) begin
                        rx_tcnt_q <= rx_tcnt_q + 4'h1;
                        if (rx_tcnt_q == OVS_MID) begin
                            rx_tcnt_q  <= 4'h0;
                            rx_bits_q  <= frame_bits - 4'h1;
                            rx_state_q <= serial_in_pin_i ? RX_IDLE : RX_BITS;
                        end
                    end
                end
                RX_BITS: begin
                    if (rx_tick) begin
                        rx_tcnt_q <= rx_tcnt_q + 4'h1;
                        if (rx_tcnt_q == OVS_LAST) begin
                            rx_sh_q   <= fr;
                            rx_bits_q <= rx_bits_q - 4'h1;
                            if (rx_bits_q == 4'h1) begin
                                rx_state_q <= RX_IDLE;
                            end
                        end
                    end
                end
                RX_SYNC: begin
                    if (sph_q == SYNC_CLK_RISE && rx_bits_q != 4'h0) begin
                        rx_sh_q   <= fr;
                        rx_bits_q <= rx_bits_q - 4'h1;
                    end
                    if (sync_end) begin
                        rx_state_q <= RX_IDLE;
                    end
                end
                default: rx_state_q <= RX_IDLE;
            endcase
        end
    end

    // two-entry holding buffer; head feeds the reader straight from flops
    assign pop = rx_rd_ready && head_v_q;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            head_q   <= WORD_RST;
            tail_q   <= WORD_RST;
            head_v_q <= 1'b0;
            tail_v_q <= 1'b0;
        end else if (pop) begin
            head_q   <= tail_v_q ? tail_q : rx_word;
            head_v_q <= tail_v_q | rx_load;
            tail_q   <= rx_word;
            tail_v_q <= tail_v_q & rx_load;
        end else if (rx_load) begin
            if (head_v_q) begin
                tail_q   <= rx_word;
                tail_v_q <= 1'b1;
            end else begin
                head_q   <= rx_word;
                head_v_q <= 1'b1;
            end
        end
    end

    // sticky flags: a set in the clearing cycle wins, and only software clears
    assign set_w.frame_error_flag        = async_end && !rx_stop;
    assign set_w.receive_overrun_flag    = rx_qual && !sync_end
                                         && !status_q.rx_done_flag
                                         && head_v_q && !pop;
    assign set_w.transmit_collision_flag = tx_collide;
    assign set_w.tx_done_flag            = tx_ti_evt;
    assign set_w.rx_done_flag            = rx_load;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            status_q <= STATUS_RST;
        end else begin
            status_q <= set_w | (status_q & ~flag_clr);
        end
    end

    // pin drivers and interrupt, all registered
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_q     <= 1'b0;
            out_pin_q <= 1'b1;
            in_o_q    <= 1'b0;
            in_oe_n_q <= 1'b1;
        end else begin
            irq_q     <= cfg.irq_enable
                       & (status_q.tx_done_flag | status_q.rx_done_flag);
            out_pin_q <= (tx_state_q == TX_SYNC || rx_state_q == RX_SYNC)
                       ? (sph_q >= SYNC_CLK_RISE)
                       : (tx_state_q == TX_ASYNC ? tx_sh_q[0] : 1'b1);
            in_o_q    <= 1'b0;
            // open drain: pull low only for a zero bit, the pull-up makes the ones
            in_oe_n_q <= !(tx_state_q == TX_SYNC && !tx_sh_q[0]);
        end
    end

    assign rx_rd_valid        = head_v_q;
    assign serial_buffer      = head_q;
    assign status             = status_q;
    assign serial_irq         = irq_q;
    assign serial_out_pin     = out_pin_q;
    assign serial_in_pin_o    = in_o_q;
    assign serial_in_pin_oe_n = in_oe_n_q;
endmodule

// [sim/serial_port_asserts.sv]
// port-level assertions for the serial port
`timescale 1ns/1ps
module serial_port_asserts (
    input wire logic                         mclk,
    input wire logic                         sys_rst,
    input wire serial_port_pkg::serial_cfg_t cfg,
    input wire logic                         tx_wr,
    input wire serial_port_pkg::status_t     flag_clr,
    input wire logic                         rx_rd_valid,
    input wire serial_port_pkg::status_t     status,
    input wire logic                         serial_irq,
    input wire logic                         serial_out_pin,
    input wire logic                         serial_in_pin_oe_n
);
    import serial_port_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // interrupt, done flags and the buffer
    chk_irq_gate: assert property (
        serial_irq == $past(cfg.irq_enable && (status.tx_done_flag || status.rx_done_flag)))
        else $error("irq does not follow the done flags");
    chk_tx_sticky: assert property (
        status.tx_done_flag && !flag_clr.tx_done_flag |=> status.tx_done_flag)
        else $error("tx done dropped without a clear");
    chk_rx_sticky: assert property (
        status.rx_done_flag && !flag_clr.rx_done_flag |=> status.rx_done_flag)
        else $error("rx done dropped without a clear");
    chk_load_valid: assert property (
        $rose(status.rx_done_flag) |-> rx_rd_valid)
        else $error("rx done rose with no word held");
    // pins and transmit timing
    chk_async_no_drive: assert property (
        cfg.mode != MODE_SYNC && $past(cfg.mode) != MODE_SYNC |-> serial_in_pin_oe_n)
        else $error("input pin pulled outside sync mode");
    chk_stop_high: assert property (
        $rose(status.tx_done_flag) && cfg.mode != MODE_SYNC
            |=> serial_out_pin[*8])
        else $error("tx done rose outside the stop bit");
    chk_shift_clock: assert property (
        cfg.mode == MODE_SYNC && $fell(serial_out_pin)
            |-> (!serial_out_pin)[*6] ##1 serial_out_pin[*6])
        else $error("shift clock period is not twelve clocks");
    chk_write_collide: assert property (
        tx_wr && ($past(tx_wr) || $past(tx_wr, 2)) |=> status.transmit_collision_flag)
        else $error("write while busy did not flag a collision");
endmodule

bind serial_port serial_port_asserts chk_u (
    .mclk(mclk), .sys_rst(sys_rst), .cfg(cfg), .tx_wr(tx_wr), .flag_clr(flag_clr),
    .rx_rd_valid(rx_rd_valid), .status(status), .serial_irq(serial_irq),
    .serial_out_pin(serial_out_pin), .serial_in_pin_oe_n(serial_in_pin_oe_n)
);

// [sim/remote_serial_dev.sv]
// remote serial device that drives and watches the port's pins
`timescale 1ns/1ps
module remote_serial_dev (
    input  wire logic mclk,
    input  wire logic out_pin,
    input  wire logic wire_line,
    output logic      line_drv
);
    initial line_drv = 1'b1;

    // frame goes out lsb first, start bit in bit 0; released line floats high
    task automatic send(input logic [10:0] bits, input int n, input int cpb);
        for (int i = 0; i < n; i++) begin
            line_drv <= bits[i];
            repeat (cpb) @(negedge mclk);
        end
        line_drv <= 1'b1;
    endtask

    // finds the start edge, then samples each bit near its centre
    task automatic recv(output logic [10:0] w, input int n, input int cpb);
        w = 11'h000;
        @(negedge out_pin);
        repeat (cpb / 2) @(negedge mclk);
        for (int i = 0; i < n; i++) begin
            w[i] = out_pin;
            repeat (cpb) @(negedge mclk);
        end
    endtask

    // sync slave: data wire sampled on each rising shift clock
    task automatic shift_recv(output logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            @(posedge out_pin);
            b[i] = wire_line;
        end
    endtask

    // sync slave: bit on the wire before each rising shift clock
    task automatic shift_send(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            line_drv <= b[i];
            @(posedge out_pin);
        end
        line_drv <= 1'b1;
    endtask
endmodule

// [sim/serial_port_tb_top.sv]
// self-checking bench for the four-mode serial port
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin errors++; \
    $display("BAD %s expected %h seen %h", nm, exp, got); end end
module serial_port_tb_top;
    import serial_port_pkg::*;
    logic        mclk, sys_rst, tx_wr, rx_rd_ready, rx_rd_valid, serial_irq;
    logic        serial_out_pin, pin_o, pin_oe_n, line_drv, pin_level;
    logic        eight_bit_timer_ovf   = 1'b0;
    logic [2:0]  sixteen_bit_timer_ovf = 3'h0;
    logic [1:0]  tick_cnt              = 2'h0;
    logic [7:0]  tx_wr_data;
    serial_cfg_t cfg;
    status_t     flag_clr, status;
    rx_word_t    serial_buffer;
    int          errors, cmp_count;

    // open-drain data wire: pulled up, low while either side pulls it
    assign pin_level = line_drv & (pin_oe_n | pin_o);

    serial_port dut_u (
        .mclk(mclk), .sys_rst(sys_rst), .cfg(cfg), .eight_bit_timer_ovf(eight_bit_timer_ovf),
        .sixteen_bit_timer_ovf(sixteen_bit_timer_ovf), .tx_wr(tx_wr), .tx_wr_data(tx_wr_data),
        .flag_clr(flag_clr), .rx_rd_ready(rx_rd_ready), .rx_rd_valid(rx_rd_valid),
        .serial_buffer(serial_buffer), .status(status), .serial_irq(serial_irq),
        .serial_out_pin(serial_out_pin), .serial_in_pin_i(pin_level),
        .serial_in_pin_o(pin_o), .serial_in_pin_oe_n(pin_oe_n)
    );
    remote_serial_dev far_u (
        .mclk(mclk), .out_pin(serial_out_pin), .wire_line(pin_level), .line_drv(line_drv)
    );

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // timer overflows: 8-bit every 2 clocks, 16-bit every 4 clocks
    always @(negedge mclk) begin
        tick_cnt              <= tick_cnt + 2'h1;
        eight_bit_timer_ovf   <= tick_cnt[0];
        sixteen_bit_timer_ovf <= {3{&tick_cnt}};
    end

    // bits is {check, enable, ninth, doubler}, sel is {tx select, rx select}
    task automatic setup(input mode_t m, input logic [3:0] bits, input logic [3:0] sel);
        cfg = {m, bits, sel, 8'h35, 8'h0f, 1'b1};
        @(negedge mclk);
    endtask
    task automatic wr(input logic [7:0] d);
        tx_wr      = 1'b1;
        tx_wr_data = d;
        @(negedge mclk);
        tx_wr      = 1'b0;
    endtask
    task automatic clr(input status_t f);
        flag_clr = f;
        @(negedge mclk);
        flag_clr = STATUS_RST;
    endtask
    // extra edge after the pop so the next head has landed
    task automatic pop;
        rx_rd_ready = 1'b1;
        @(negedge mclk);
        rx_rd_ready = 1'b0;
        @(negedge mclk);
    endtask
    task automatic tx_frame(input logic [7:0] d, input logic [10:0] exp, input int n,
                            input int cpb);
        logic [10:0] w;
        fork
            far_u.recv(w, n, cpb);
            wr(d);
        join
        `CHK("frame", exp, w)
    endtask

    task automatic t_tx_fixed9;
        logic [10:0] w;
        setup(MODE_FIXED9, 4'h3, 4'h0);
        fork
            far_u.recv(w, 11, 32);
            begin
                wr(8'ha5);
                @(negedge mclk);
                wr(8'h0f);
            end
        join
        `CHK("frame9", {2'b11, 8'ha5, 1'b0}, w)
        `CHK("tx_done", 1'b1, status.tx_done_flag)
        `CHK("collide", 1'b1, status.transmit_collision_flag)
        `CHK("irq", 1'b1, serial_irq)
        clr(5'h1f);
        `CHK("cleared", STATUS_RST, status)
        repeat (40) @(negedge mclk);
    endtask

    // timer-fed baud: every 2nd 8-bit overflow, every one with doubler, 16-bit select
    task automatic t_tx_timer;
        setup(MODE_ASYNC8, 4'h0, 4'h0);
        tx_frame(8'hc3, {2'b01, 8'hc3, 1'b0}, 10, 64);
        setup(MODE_ASYNC8, 4'h1, 4'h0);
        tx_frame(8'h5a, {2'b01, 8'h5a, 1'b0}, 10, 32);
        setup(MODE_VAR9, 4'h0, 4'h4);
        tx_frame(8'h3c, {2'b10, 8'h3c, 1'b0}, 11, 64);
    endtask

    task automatic t_sync_tx;
        logic [7:0] b;
        setup(MODE_SYNC, 4'h0, 4'h0);
        clr(5'h1f);
        fork
            far_u.shift_recv(b);
            wr(8'h5a);
        join
        `CHK("sync_data", 8'h5a, b)
        `CHK("sync_early", 1'b0, status.tx_done_flag)
        repeat (8) @(negedge mclk);
        `CHK("sync_done", 1'b1, status.tx_done_flag)
        `CHK("sync_release", 1'b1, pin_oe_n)
    endtask

    // reader stalls while three frames arrive at the two-entry buffer; the third is dropped
    task automatic t_rx_fill;
        setup(MODE_ASYNC8, 4'h5, 4'h0);
        clr(5'h1f);
        far_u.send({1'b1, 8'h11, 1'b0}, 10, 32);
        repeat (2) @(negedge mclk);
        `CHK("rx_done", 1'b1, status.rx_done_flag)
        `CHK("word1", 9'h111, serial_buffer)
        clr(5'h01);
        far_u.send({1'b1, 8'h22, 1'b0}, 10, 32);
        repeat (2) @(negedge mclk);
        `CHK("overrun", 1'b1, status.receive_overrun_flag)
        clr(5'h01);
        far_u.send({1'b1, 8'h33, 1'b0}, 10, 32);
        repeat (2) @(negedge mclk);
        `CHK("full_refused", 1'b0, status.rx_done_flag)
        `CHK("head_kept", 9'h111, serial_buffer)
        pop;
        `CHK("word2", 9'h122, serial_buffer)
        pop;
        `CHK("drained", 1'b0, rx_rd_valid)
        setup(MODE_ASYNC8, 4'hd, 4'h0);
        clr(5'h1f);
        far_u.send({1'b0, 8'h44, 1'b0}, 10, 32);
        repeat (2) @(negedge mclk);
        `CHK("bad_stop", 1'b0, status.rx_done_flag)
        `CHK("frame_err", 1'b1, status.frame_error_flag)
    endtask

    // {load, ninth, byte}; address 0x35 mask 0x0f, broadcast 0x3f
    task automatic t_addr;
        logic [9:0] tbl [5] = '{10'h3f5, 10'h3ff, 10'h33f, 10'h1f6, 10'h0f5};
        setup(MODE_FIXED9, 4'hd, 4'h0);
        clr(5'h1f);
        foreach (tbl[i]) begin
            far_u.send({1'b1, tbl[i][8:0], 1'b0}, 11, 32);
            repeat (2) @(negedge mclk);
            `CHK("addr_load", tbl[i][9], status.rx_done_flag)
            if (tbl[i][9]) begin
                `CHK("addr_word", tbl[i][8:0], serial_buffer)
                pop;
                clr(5'h01);
            end
        end
        setup(MODE_FIXED9, 4'h5, 4'h0);
        far_u.send({2'b10, 8'h42, 1'b0}, 11, 32);
        repeat (2) @(negedge mclk);
        `CHK("data_word", 9'h042, serial_buffer)
    endtask

    // sync receive starts once rx done is cleared
    task automatic t_sync_rx;
        setup(MODE_SYNC, 4'h4, 4'h0);
        pop;
        clr(5'h01);
        far_u.shift_send(8'h96);
        repeat (8) @(negedge mclk);
        `CHK("srx_done", 1'b1, status.rx_done_flag)
        `CHK("srx_word", 9'h096, serial_buffer)
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // the scenarios need about 6000 clocks; cut a hang well beyond that
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        test_done;
    end

    initial begin
        sys_rst     = 1'b1;
        cfg         = '0;
        tx_wr       = 1'b0;
        tx_wr_data  = 8'h00;
        flag_clr    = STATUS_RST;
        rx_rd_ready = 1'b0;
        errors      = 0;
        cmp_count   = 0;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        sys_rst = 1'b0;
        `CHK("rst_status", STATUS_RST, status)
        `CHK("rst_pins", 3'b110, {serial_out_pin, pin_oe_n, pin_o})
        t_tx_fixed9;
        t_tx_timer;
        t_sync_tx;
        t_rx_fill;
        t_addr;
        t_sync_rx;
        test_done;
    end
endmodule
